// >>> core/sled_pkg.sv
// Purpose: shared constants, types and decode for the status indicator block
// Assumes: 100 MHz core clock, management registers at 5-bit addresses
// Notes:   indicator index 0 = link, 1 = speed, 2 = activity/collision/duplex
package sled_pkg;

  // management register addresses
  localparam logic [4:0]  DCTL_ADDR    = 5'h18;
  localparam logic [4:0]  PCTL_ADDR    = 5'h19;
  localparam logic [15:0] DCTL_RESET   = 16'h0000;
  localparam logic [15:0] PCTL_RESET   = 16'h0000;
  localparam logic [15:0] RDATA_RESET  = 16'h0000;

  // phy control fields
  localparam int MODE_LO = 5;
  localparam int MODE_HI = 6;

  // direct control fields
  localparam int OVR_VAL_LO = 0;
  localparam int OVR_EN_LO  = 3;
  localparam int RATE_LO    = 6;
  localparam int RX_ONLY    = 8;

  // link qualification
  localparam int             LINK_PULSES = 7;
  localparam logic [2:0]     PULSE_LAST  = 3'(LINK_PULSES - 1);
  localparam int             CLK_NS        = 10;
  localparam int             FAST_LOSS_NS  = 1300;
  // longest time: rounded down
  localparam int             FAST_LOSS_CYC = FAST_LOSS_NS / CLK_NS;
  localparam int             FAST_W        = 8;
  // two cycles of pipeline to the pin plus one of margin
  localparam logic [FAST_W-1:0] FAST_LIMIT = FAST_W'(FAST_LOSS_CYC - 3);

  // blink divider
  localparam int         DIV_W      = 24;
  localparam logic [4:0] BLINK_BASE = 5'h14;

  typedef enum logic [1:0] {
    SLED_MODE1 = 2'b01,
    SLED_MODE2 = 2'b10,
    SLED_MODE3 = 2'b11
  } sled_mode_t;

  typedef struct packed {
    logic link_pulse;
    logic good_packet;
    logic link_fail;
    logic sig_detect;
    logic speed_100;
    logic full_duplex;
    logic tx_act;
    logic rx_act;
    logic mii_col;
  } sled_status_t;

  typedef struct packed {
    logic [15:0]       dctl;
    logic [15:0]       pctl;
    logic [2:0]        pol;
    logic              strap_pend;
    logic [DIV_W-1:0]  blink_div;
    logic [2:0]        pulse_cnt;
    logic              link10;
    logic              link100;
    logic [FAST_W-1:0] fast_cnt;
    logic [2:0]        leds;
    logic              crs;
    logic              col;
    logic [15:0]       rdata;
  } sled_state_t;

  // low bit set wins regardless of the high bit
  function automatic sled_mode_t mode_of(input logic [1:0] cfg);
    if (cfg[0]) begin
      return SLED_MODE1;
    end else if (cfg[1]) begin
      return SLED_MODE3;
    end
    return SLED_MODE2;
  endfunction : mode_of

endpackage : sled_pkg

// >>> core/sled_core.sv
// Purpose: drives link, speed and activity indicators, carrier sense and
//          collision report from internal link, speed and duplex state
// Assumes: all inputs synchronous to mclk; strap levels valid on the first cycle after rst
// Notes:   registers written through a simple management port
//
// Functional notes
// - mode field at phy control bits 6:5
// - upper mode bit set by write only
// - low bit selects mode 1, else 2/3
// - mode 1 link on good, off none
// - 100 Mb/s link follows signal detect
// - 10 Mb/s link: seven pulses or packet
// - fast loss drops link within 1.3 us
// - modes 2/3 link blinks on activity
// - activity source: both, or receive only
// - speed indicator high at 100 Mb/s
// - third indicator: activity mode1, collision mode2
// - third indicator shows full duplex in mode3
// - 10 Mb/s half collision from COL
// - strap level sets each indicator polarity
// - direct control forces the three indicators, reads hide pins
// - half duplex carrier on tx or rx
// - full duplex: no collision, carrier rx
`timescale 1ns/1ns

module sled_core (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [4:0]            mgmt_addr,
  input  wire logic                  mgmt_wr,
  input  wire logic [15:0]           mgmt_wdata,
  output logic      [15:0]           mgmt_rdata,
  input  wire sled_pkg::sled_status_t sts_in,
  input  wire logic                  fast_loss_time,
  input  wire logic [2:0]            strap_in,
  input  wire logic                  negotiation_strap_0,
  output logic                       link_indicator_out,
  output logic                       speed_indicator_out,
  output logic                       activity_indicator_out,
  output logic                       carrier_sense_out,
  output logic                       collision_out
);

  sled_pkg::sled_state_t q;
  sled_pkg::sled_state_t d;

  sled_pkg::sled_mode_t  mode;
  logic                  link_ok;
  logic                  act;
  logic                  col_int;
  logic                  blink;
  logic [4:0]            blink_idx;
  logic [2:0]            raw;
  logic [2:0]            ovr_en;
  logic [2:0]            ovr_val;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    mode      = sled_pkg::mode_of(q.pctl[sled_pkg::MODE_HI:sled_pkg::MODE_LO]);
    link_ok   = 1'b0;
    act       = 1'b0;
    col_int   = 1'b0;
    blink     = 1'b0;
    blink_idx = 5'h00;
    raw       = 3'h0;
    ovr_en    = q.dctl[sled_pkg::OVR_EN_LO +: 3];
    ovr_val   = q.dctl[sled_pkg::OVR_VAL_LO +: 3];
    d         = q;

    // straps caught on the first cycle after release, never under reset
    d.strap_pend = 1'b0;
    if (q.strap_pend) begin
      d.pol = strap_in;
      // only the low mode bit has a strap
      d.pctl[sled_pkg::MODE_LO] = negotiation_strap_0;
    end

    if (mgmt_wr) begin
      if (mgmt_addr == sled_pkg::DCTL_ADDR) begin
        d.dctl = mgmt_wdata;
      end else if (mgmt_addr == sled_pkg::PCTL_ADDR) begin
        d.pctl = mgmt_wdata;
      end
    end

    // read data is the stored register, never the pin level
    if (mgmt_addr == sled_pkg::DCTL_ADDR) begin
      d.rdata = q.dctl;
    end else if (mgmt_addr == sled_pkg::PCTL_ADDR) begin
      d.rdata = q.pctl;
    end else begin
      d.rdata = sled_pkg::RDATA_RESET;
    end

    d.blink_div = q.blink_div + sled_pkg::DIV_W'(1);
    blink_idx = sled_pkg::BLINK_BASE
              + {3'h0, q.dctl[sled_pkg::RATE_LO +: 2]};
    blink = q.blink_div[blink_idx];

    // 10 Mb/s link qualification; link fail also breaks the pulse run
    if (sts_in.link_fail) begin
      d.pulse_cnt = 3'h0;
      d.link10    = 1'b0;
    end else if (sts_in.good_packet) begin
      d.link10 = 1'b1;
    end else if (sts_in.link_pulse) begin
      if (q.pulse_cnt == sled_pkg::PULSE_LAST) begin
        d.link10 = 1'b1;
      end else begin
        d.pulse_cnt = q.pulse_cnt + 3'h1;
      end
    end

    // 100 Mb/s link follows signal detect
    if (sts_in.sig_detect) begin
      d.link100  = 1'b1;
      d.fast_cnt = '0;
    end else if (fast_loss_time) begin
      if (q.fast_cnt == sled_pkg::FAST_LIMIT) begin
        d.link100 = 1'b0;
      end else begin
        d.fast_cnt = q.fast_cnt + sled_pkg::FAST_W'(1);
      end
    end else if (sts_in.link_fail) begin
      d.link100 = 1'b0;
    end

    link_ok = sts_in.speed_100 ? q.link100 : q.link10;

    if (q.dctl[sled_pkg::RX_ONLY]) begin
      act = sts_in.rx_act;
    end else begin
      act = sts_in.tx_act | sts_in.rx_act;
    end

    // collision only exists in half duplex
    if (!sts_in.full_duplex) begin
      if (sts_in.speed_100) begin
        col_int = sts_in.tx_act & sts_in.rx_act;
      end else begin
        col_int = sts_in.mii_col;
      end
    end
    d.col = col_int;

    if (sts_in.full_duplex) begin
      d.crs = sts_in.rx_act;
    end else begin
      d.crs = sts_in.tx_act | sts_in.rx_act;
    end

    raw[1] = sts_in.speed_100;
    unique case (mode)
      sled_pkg::SLED_MODE1: begin
        raw[0] = link_ok;
        raw[2] = act;
      end
      sled_pkg::SLED_MODE2: begin
        raw[0] = link_ok & (~act | blink);
        raw[2] = col_int;
      end
      sled_pkg::SLED_MODE3: begin
        raw[0] = link_ok & (~act | blink);
        raw[2] = sts_in.full_duplex;
      end
    endcase

    // override ahead of polarity; a high strap inverts the driver
    for (int i = 0; i < 3; i++) begin
      d.leds[i] = (ovr_en[i] ? ovr_val[i] : raw[i]) ^ q.pol[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk) begin
    if (rst) begin
      q.dctl       <= sled_pkg::DCTL_RESET;
      q.pctl       <= sled_pkg::PCTL_RESET;
      q.pol        <= 3'h0;
      q.strap_pend <= 1'b1;
      q.blink_div  <= '0;
      q.pulse_cnt  <= 3'h0;
      q.link10     <= 1'b0;
      q.link100    <= 1'b0;
      q.fast_cnt   <= '0;
      q.leds       <= 3'h0;
      q.crs        <= 1'b0;
      q.col        <= 1'b0;
      q.rdata      <= sled_pkg::RDATA_RESET;
    end else begin
      q <= d;
    end
  end

  assign link_indicator_out     = q.leds[0];
  assign speed_indicator_out    = q.leds[1];
  assign activity_indicator_out = q.leds[2];
  assign carrier_sense_out      = q.crs;
  assign collision_out          = q.col;
  assign mgmt_rdata             = q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic [8:0] lost_cnt;

  // cycles the wire has been silent with fast loss on at 100 Mb/s
  always_ff @(posedge mclk) begin
    if (rst || sts_in.sig_detect || !fast_loss_time || !sts_in.speed_100) begin
      lost_cnt <= 9'h000;
    end else if (lost_cnt != 9'h1FF) begin
      lost_cnt <= lost_cnt + 9'h001;
    end
  end

  sequence s_pkt10;
    !q.strap_pend && !sts_in.speed_100 && sts_in.good_packet
      && !sts_in.link_fail;
  endsequence

  sequence s_show10;
    !sts_in.speed_100 && !sts_in.link_fail && !ovr_en[0]
      && mode == sled_pkg::SLED_MODE1 && !mgmt_wr;
  endsequence

  a_mode_strap: assert property (q.strap_pend && !mgmt_wr |=>
    !q.pctl[sled_pkg::MODE_HI])
    else $error("upper mode bit loaded at reset");

  a_pol_held: assert property (!q.strap_pend |=> $stable(q.pol))
    else $error("polarity changed after release");

  a_speed_level: assert property (!q.strap_pend && !ovr_en[1] |=>
    speed_indicator_out == ($past(sts_in.speed_100) ^ q.pol[1]))
    else $error("speed indicator wrong");

  a_link10_up: assert property (s_pkt10 ##1 s_show10 |=>
    link_indicator_out == ~q.pol[0])
    else $error("10 Mb/s link not shown after packet");

  a_mode1_nolink: assert property (!q.strap_pend && !ovr_en[0]
    && mode == sled_pkg::SLED_MODE1 && !link_ok |=>
    link_indicator_out == q.pol[0])
    else $error("link indicator on without link");

  a_fast_loss: assert property (lost_cnt >= 9'(sled_pkg::FAST_LOSS_CYC)
    && !ovr_en[0] && !q.strap_pend |->
    link_indicator_out == q.pol[0])
    else $error("fast link loss too slow");

  a_link_blink: assert property (!q.strap_pend && !ovr_en[0] && link_ok
    && act && mode != sled_pkg::SLED_MODE1 |=>
    link_indicator_out == ($past(blink) ^ q.pol[0]))
    else $error("link indicator not blinking");

  a_rx_only: assert property (!q.strap_pend && !ovr_en[2]
    && mode == sled_pkg::SLED_MODE1 && q.dctl[sled_pkg::RX_ONLY]
    && !sts_in.rx_act |=> activity_indicator_out == q.pol[2])
    else $error("transmit counted as activity");

  a_mode2_col: assert property (!q.strap_pend && !ovr_en[2]
    && mode == sled_pkg::SLED_MODE2 |=>
    activity_indicator_out == (collision_out ^ q.pol[2]))
    else $error("collision indicator wrong");

  a_mode3_dup: assert property (!q.strap_pend && !ovr_en[2]
    && mode == sled_pkg::SLED_MODE3 |=>
    activity_indicator_out == ($past(sts_in.full_duplex) ^ q.pol[2]))
    else $error("duplex indicator wrong");

  a_col_10m: assert property (!sts_in.speed_100
    && !sts_in.full_duplex |=>
    collision_out == $past(sts_in.mii_col))
    else $error("10 Mb/s collision not from COL");

  a_full_dup: assert property (sts_in.full_duplex |=>
    !collision_out && carrier_sense_out == $past(sts_in.rx_act))
    else $error("full duplex collision or carrier wrong");

  a_half_crs: assert property (!sts_in.full_duplex
    && sts_in.tx_act |=>
    carrier_sense_out)
    else $error("half duplex carrier missed transmit");

  a_override: assert property (!q.strap_pend && ovr_en[2] |=>
    activity_indicator_out == ($past(ovr_val[2]) ^ q.pol[2]))
    else $error("direct control not forcing output");

endmodule : sled_core

// >>> testbench/sled_led_model.sv
// Purpose: lamps and strap resistors hung on the indicator pins
// Assumes: strap pulls are fixed resistors, static for the whole run
// Notes:   lit reports a glowing lamp whatever the pin's active level
`timescale 1ns/1ns

module sled_led_model #(
  parameter logic [2:0] PULL     = 3'h5,
  parameter logic       PULL_NEG0 = 1'h1
) (
  input  wire logic [2:0] pins,
  output logic      [2:0] strap,
  output logic            strap_neg0,
  output logic      [2:0] lit
);
  assign strap     = PULL;
  assign strap_neg0 = PULL_NEG0;
  // a pulled-up pin sinks the lamp current, so it glows when driven low
  assign lit = pins ^ PULL;
endmodule : sled_led_model

// >>> testbench/tb_top.sv
// Purpose: register and indicator checks of the status indicator block
// Assumes: inputs change at the falling edge, outputs settle in 2 edges
// Notes:   blink timing is too slow for this run, an active link in modes 2/3 is seen steady-off
`timescale 1ns/1ns

module tb_top;
  logic                   mclk;
  logic                   rst;
  logic [4:0]             mgmt_addr;
  logic                   mgmt_wr;
  logic [15:0]            mgmt_wdata;
  logic [15:0]            mgmt_rdata;
  sled_pkg::sled_status_t sts;
  logic                   fast_loss_time;
  logic [2:0]             strap_in;
  logic                   strap_neg0;
  logic [2:0]             pins;
  logic [2:0]             lit;
  logic                   crs_o;
  logic                   col_o;
  int                     n_errors;
  int                     checks;
  int                     cyc;

  sled_led_model #(.PULL(3'h5), .PULL_NEG0(1'h1)) u_leds (
    .pins(pins), .strap(strap_in), .strap_neg0(strap_neg0), .lit(lit));

  sled_core u_dut (
    .mclk(mclk), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .sts_in(sts),
    .fast_loss_time(fast_loss_time), .strap_in(strap_in),
    .negotiation_strap_0(strap_neg0), .link_indicator_out(pins[0]),
    .speed_indicator_out(pins[1]), .activity_indicator_out(pins[2]),
    .carrier_sense_out(crs_o), .collision_out(col_o));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_n

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge mclk);
    mgmt_addr  = a;
    mgmt_wr    = 1'h1;
    mgmt_wdata = d;
    @(negedge mclk);
    mgmt_wr = 1'h0;
  endtask : wr

  task automatic rd(input string what, input logic [4:0] a,
                    input logic [15:0] exp);
    @(negedge mclk);
    mgmt_addr = a;
    wait_n(2);
    chk(what, exp, mgmt_rdata);
  endtask : rd

  // expected order: act, speed, link lamps, then carrier, collision
  task automatic see(input string what, input logic [4:0] exp);
    wait_n(3);
    chk(what, {11'h000, exp}, {11'h000, lit, crs_o, col_o});
  endtask : see

  task automatic strobe(input int which, input int n);
    repeat (n) begin
      @(negedge mclk);
      if (which == 0) sts.link_pulse = 1'h1;
      if (which == 1) sts.link_fail = 1'h1;
      if (which == 2) sts.good_packet = 1'h1;
      @(negedge mclk);
      sts = sts & ~9'h1c0;
    end
  endtask : strobe

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // a hang costs at most this many cycles before the report
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    rst            = 1'h1;
    mgmt_addr      = 5'h00;
    mgmt_wr        = 1'h0;
    mgmt_wdata     = 16'h0000;
    sts            = '0;
    fast_loss_time = 1'h0;
    n_errors       = 0;
    checks         = 0;
    cyc            = 0;
    repeat (8) @(negedge mclk);
    rst = 1'h0;
    wait_n(2);
    rd("indicator_direct_control_reset", 5'h18, 16'h0000);
    rd("phy_control_reset", 5'h19, 16'h0020);
    wr(5'h1a, 16'hffff);
    rd("unmapped", 5'h1a, 16'h0000);
    rd("indicator_direct_control_kept", 5'h18, 16'h0000);
    $display("end registers");
    strobe(0, 6);
    see("six_pulses", 5'h00);
    strobe(0, 1);
    see("seven_pulses", 5'h04);
    strobe(1, 1);
    see("link_lost", 5'h00);
    strobe(2, 1);
    see("good_packet", 5'h04);
    sts.speed_100  = 1'h1;
    sts.sig_detect = 1'h1;
    see("speed_100", 5'h0c);
    fast_loss_time = 1'h1;
    sts.sig_detect = 1'h0;
    wait_n(129);
    chk("fast_loss", 16'h0002, {13'h0000, lit});
    sts.sig_detect = 1'h1;
    see("signal_back", 5'h0c);
    fast_loss_time = 1'h0;
    sts.speed_100  = 1'h0;
    strobe(2, 1);
    see("speed_10", 5'h04);
    $display("end link and speed");
    sts.tx_act = 1'h1;
    see("tx_act", 5'h16);
    wr(5'h18, 16'h0100);
    see("rx_only_tx", 5'h06);
    sts.tx_act = 1'h0;
    sts.rx_act = 1'h1;
    see("rx_only_rx", 5'h16);
    sts.rx_act = 1'h0;
    wr(5'h18, 16'h0000);
    sts.mii_col = 1'h1;
    see("col_mode1", 5'h05);
    wr(5'h19, 16'h0000);
    see("col_mode2", 5'h15);
    sts.full_duplex = 1'h1;
    see("col_full", 5'h04);
    sts.mii_col = 1'h0;
    $display("end activity and collision");
    wr(5'h19, 16'h0020);
    sts.tx_act = 1'h1;
    see("crs_full_tx", 5'h14);
    sts.tx_act = 1'h0;
    sts.rx_act = 1'h1;
    see("crs_full_rx", 5'h16);
    sts.rx_act = 1'h0;
    wr(5'h19, 16'h0040);
    see("mode3_full", 5'h14);
    sts.full_duplex = 1'h0;
    see("mode3_half", 5'h04);
    // the blink bit stays low for the whole run, so activity darkens link
    sts.tx_act = 1'h1;
    see("mode3_blink", 5'h02);
    wr(5'h19, 16'h0060);
    sts.tx_act = 1'h1;
    see("mode1_high_set", 5'h16);
    sts.tx_act = 1'h0;
    $display("end modes");
    wr(5'h18, 16'h003a);
    see("override", 5'h08);
    rd("override_read", 5'h18, 16'h003a);
    wr(5'h18, 16'h0000);
    see("override_off", 5'h04);
    $display("end direct control");
    conclude();
  end
endmodule : tb_top
